// >>> fp_slice_params.svh
// Shared constants of the floating-point slice and its issuing end
`ifndef FP_SLICE_PARAMS_SVH
`define FP_SLICE_PARAMS_SVH
// Rounding-mode codes as held in fp_status_control_reg
`define RM_NEAREST 2'b00
`define RM_PLUS 2'b01
`define RM_MINUS 2'b10
`define RM_ZERO 2'b11
// Operand type codes: bit 0 unsigned, bit 1 width 32
`define SIGNED_16_TYPE 2'b00
`define UNSIGNED_16_TYPE 2'b01
`define SIGNED_32_TYPE 2'b10
`define UNSIGNED_32_TYPE 2'b11
`define TYPE_UNS_BIT 0
`define TYPE_W32_BIT 1
`define SINGLE_BIAS 127
`define SINGLE_FRAC 23
`define SINGLE_EXP_MAX 255
`define HALF_BIAS 15
`define HALF_FRAC 10
`define HALF_EXP_MAX 31
`define DIV_EXTRA 50
`define FMA_LEFT_MAX 47
`define FMA_RIGHT_MAX 70
// Fraction-bit limits and multiple-load figures
`define FIX16_MAX_FBITS 16
`define FIX32_MIN_FBITS 1
`define FIX32_MAX_FBITS 32
`define MAX_DOUBLE_REGS 16
`define WORD_BYTES 4
`endif

// >>> fp_slice_pkg.sv
// Types of the floating-point slice; the operation codes are shared by both ends, the state codes are the slice's own
package fp_slice_pkg;
    typedef enum logic [3:0] {
        CONVERT_F2I_OP         = 4'h0,
        CONVERT_I2F_OP         = 4'h1,
        CONVERT_F2X_OP         = 4'h2,
        CONVERT_X2F_OP         = 4'h3,
        CONVERT_BOTTOM_HALF_OP = 4'h4,
        CONVERT_TOP_HALF_OP    = 4'h5,
        FP_DIVIDE_OP           = 4'h6,
        FUSED_MUL_ACC_OP       = 4'h7,
        FUSED_MUL_SUB_OP       = 4'h8,
        FUSED_NEG_MUL_ACC_OP   = 4'h9,
        FUSED_NEG_MUL_SUB_OP   = 4'hA,
        MULTI_REG_LOAD_OP      = 4'hB
    } op_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01
    } state_e;
endpackage

// >>> fp_link_if.sv
// Link between the issuing core end and the floating-point slice
`timescale 1ns/1ps
interface fp_link_if;
    logic               reqValid;
    fp_slice_pkg::op_e  reqOp;
    logic [31:0]        reqA;
    logic [31:0]        reqB;
    logic [31:0]        reqD;
    logic [4:0]         reqDest;
    logic               roundSel;
    logic [1:0]         reqType;
    logic               toHalf;
    logic               topHalf;
    logic [5:0]         fbits;
    logic [1:0]         rmode;
    logic [31:0]        reqBase;
    logic [5:0]         regCount;
    logic               dblRegs;
    logic               decBefore;
    logic               writeBack;
    logic               busy;
    logic               resValid;
    logic [4:0]         resIdx;
    logic [31:0]        resData;
    logic               baseValid;
    logic [31:0]        baseData;
    modport device (
        input  reqValid, reqOp, reqA, reqB, reqD, reqDest, roundSel, reqType, toHalf,
        input  topHalf, fbits, rmode, reqBase, regCount, dblRegs, decBefore, writeBack,
        output busy, resValid, resIdx, resData, baseValid, baseData
    );
    modport host (
        output reqValid, reqOp, reqA, reqB, reqD, reqDest, roundSel, reqType, toHalf,
        output topHalf, fbits, rmode, reqBase, regCount, dblRegs, decBefore, writeBack,
        input  busy, resValid, resIdx, resData, baseValid, baseData
    );
endinterface

// >>> fp_convert_fma_load_unit.sv
// Floating-point convert, divide, fused multiply and multiple-load slice
// Summary of operation
// - Float-to-int rounds to zero unless selected
// - Int-to-float uses status-register rounding mode
// - 32-bit signed or unsigned integer operand
// - Issuer gives 0..16 fraction bits for 16-bit
// - Issuer gives 1..32 fraction bits for 32-bit
// - Fixed source uses only low-order bits
// - Signed fixed result sign-extends to 32
// - Unsigned fixed result zero-extends to 32
// - To-fixed rounds zero, from-fixed rounds nearest
// - Fixed conversion reads and writes same register
// - Bottom half bits 15:0, top 31:16
// - Single-to-half keeps other half unchanged
// - Divide first operand by second
// - Fused add of unrounded product to destination
// - Fused subtract negates first operand, adds
// - Negated fused accumulate negates both terms
// - Negated fused subtract negates destination only
// - No operation changes condition flags
// - Ascending from base, or ending below base
// - Issuer requests write-back for decrement-before
// - Explicit size equals listed register width
// - One to sixteen doubles, at least one
`timescale 1ns/1ps
`include "fp_slice_params.svh"
module fp_convert_fma_load_unit (
    input  wire logic        clk,
    input  wire logic        rst_n,
    fp_link_if.device        link,
    output logic             memRead,
    output logic [31:0]      memAddr,
    input  wire logic [31:0] memData
);
    fp_slice_pkg::state_e state, next_state;
    logic        busy, next_busy, resValid, next_resValid, baseValid, next_baseValid;
    logic        next_memRead, rdPend, next_rdPend, wb, next_wb;
    logic [4:0]  resIdx, next_resIdx, idx, next_idx;
    logic [31:0] resData, next_resData, baseData, next_baseData, addr, next_addr;
    logic [31:0] next_memAddr;
    logic [6:0]  left, next_left;

    // Round-increment decision shared by every rounding path
    function automatic logic roundUp(input logic sgn, input logic [1:0] rm, input logic lsb,
            input logic g, input logic s);
        case (rm)
            `RM_NEAREST: roundUp = g & (s | lsb);
            `RM_PLUS: roundUp = ~sgn & (g | s);
            `RM_MINUS: roundUp = sgn & (g | s);
            default: roundUp = 1'b0;
        endcase
    endfunction

    // Value is sgn * mag * 2^e; one rounding to single or half, subnormals flush
    function automatic logic [31:0] pack(input logic sgn, input int e, input logic [95:0] mag,
            input logic [1:0] rm, input logic half);
        int p, sh, fw, be;
        logic [95:0] k;
        logic g, s;
        fw = half ? `HALF_FRAC : `SINGLE_FRAC;
        p = -1;
        g = 1'b0;
        s = 1'b0;
        for (int i = 0; i < 96; i++) begin
            if (mag[i]) p = i;
        end
        sh = p - fw;
        if (sh > 0) begin
            k = mag >> sh;
            g = mag[sh-1];
            s = |(mag & ((96'h1 << (sh - 1)) - 96'h1));
        end else begin
            k = mag << (-sh);
        end
        k = k + {95'h0, roundUp(sgn, rm, k[0], g, s)};
        be = p + e + (half ? `HALF_BIAS : `SINGLE_BIAS);
        if (k[fw+1]) be = be + 1; // Carry out of rounding, fraction already zero
        if (p < 0 || be <= 0)
            pack = half ? {16'h0000, sgn, 15'h0000} : {sgn, 31'h0};
        else if (half && be >= `HALF_EXP_MAX)
            pack = {16'h0000, sgn, 5'h1F, 10'h000};
        else if (half)
            pack = {16'h0000, sgn, be[4:0], k[9:0]};
        else if (be >= `SINGLE_EXP_MAX)
            pack = {sgn, 8'hFF, 23'h00_0000};
        else
            pack = {sgn, be[7:0], k[22:0]};
    endfunction

    // Float to integer or fixed point, saturating, with the given rounding
    function automatic logic [31:0] toFix(input logic [31:0] f, input int fb,
            input logic [1:0] ty, input logic [1:0] rm);
        int sh;
        logic [95:0] m, q;
        logic [32:0] hi, v;
        logic g, s, uns, w32;
        uns = ty[`TYPE_UNS_BIT];
        w32 = ty[`TYPE_W32_BIT];
        m = {72'h0, 1'b1, f[22:0]};
        sh = int'(f[30:23]) - `SINGLE_BIAS - `SINGLE_FRAC + fb;
        g = 1'b0;
        s = 1'b0;
        q = '0;
        if (f[30:23] == 8'h00) q = '0;
        else if (sh > 40) q = '1;
        else if (sh >= 0) q = m << sh;
        else if (sh < -60) s = 1'b1;
        else begin
            q = m >> (-sh);
            g = m[-sh-1];
            s = |(m & ((96'h1 << (-sh - 1)) - 96'h1));
        end
        q = q + {95'h0, roundUp(f[31], rm, q[0], g, s)};
        if (uns) hi = w32 ? 33'h0_FFFF_FFFF : 33'h0_0000_FFFF;
        else hi = (w32 ? 33'h0_7FFF_FFFF : 33'h0_0000_7FFF) + {32'h0, f[31]};
        v = (q > {63'h0, hi}) ? hi : q[32:0];
        if (uns && f[31]) v = '0;
        if (f[31]) v = -v;
        if (w32) toFix = v[31:0];
        else if (uns) toFix = {16'h0000, v[15:0]};
        else toFix = {{16{v[15]}}, v[15:0]};
    endfunction

    // Single-cycle arithmetic for every operation but the multiple load
    function automatic logic [31:0] compute(input fp_slice_pkg::op_e op, input logic [31:0] a,
            input logic [31:0] b, input logic [31:0] d, input logic [1:0] ty, input logic rsel,
            input logic toH, input logic top, input int fb, input logic [1:0] rm);
        logic [31:0] x, hv;
        logic [15:0] h;
        logic [73:0] q;
        logic [47:0] prod;
        logic [95:0] xp, xd, md;
        logic neg, sp, sd;
        int ea, eb, ed, ep, df;
        ea = int'(a[30:23]) - `SINGLE_BIAS - `SINGLE_FRAC;
        eb = int'(b[30:23]) - `SINGLE_BIAS - `SINGLE_FRAC;
        ed = int'(d[30:23]) - `SINGLE_BIAS - `SINGLE_FRAC;
        md = {72'h0, |d[30:23], d[22:0]};
        neg = ~ty[`TYPE_UNS_BIT] & a[31];
        x = '0;
        compute = '0;
        case (op)
            fp_slice_pkg::CONVERT_F2I_OP:
                compute = toFix(a, 0, ty, rsel ? rm : `RM_ZERO);
            fp_slice_pkg::CONVERT_I2F_OP:
                compute = pack(neg, 0, {64'h0, neg ? -a : a}, rm, 1'b0);
            fp_slice_pkg::CONVERT_F2X_OP:
                compute = toFix(d, fb, ty, `RM_ZERO);
            fp_slice_pkg::CONVERT_X2F_OP: begin
                if (ty[`TYPE_W32_BIT]) x = d;
                else x = {{16{~ty[`TYPE_UNS_BIT] & d[15]}}, d[15:0]};
                neg = ~ty[`TYPE_UNS_BIT] & x[31];
                compute = pack(neg, -fb, {64'h0, neg ? -x : x}, `RM_NEAREST, 1'b0);
            end
            fp_slice_pkg::CONVERT_BOTTOM_HALF_OP, fp_slice_pkg::CONVERT_TOP_HALF_OP: begin
                if (toH) begin
                    hv = pack(a[31], ea, {72'h0, |a[30:23], a[22:0]}, rm, 1'b1);
                    compute = top ? {hv[15:0], d[15:0]} : {d[31:16], hv[15:0]};
                end else begin
                    h = top ? a[31:16] : a[15:0];
                    compute = pack(h[15], int'(h[14:10]) - `HALF_BIAS - `HALF_FRAC,
                                   {85'h0, |h[14:10], h[9:0]}, `RM_NEAREST, 1'b0);
                end
            end
            fp_slice_pkg::FP_DIVIDE_OP: begin
                // Extra quotient bits plus a sticky remainder bit give exact rounding
                q = {a[30:23] != 8'h00, a[22:0], 50'h0} / {50'h0, 1'b1, b[22:0]};
                if (b[30:23] == 8'h00) compute = {a[31] ^ b[31], 8'hFF, 23'h00_0000};
                else compute = pack(a[31] ^ b[31], ea - eb - `DIV_EXTRA - 1,
                    {21'h0, q, |({a[30:23] != 8'h00, a[22:0], 50'h0} % {50'h0, 1'b1, b[22:0]})},
                    rm, 1'b0);
            end
            default: begin
                // Product kept at full 48 bits, single rounding in pack
                neg = (op == fp_slice_pkg::FUSED_MUL_SUB_OP) ||
                      (op == fp_slice_pkg::FUSED_NEG_MUL_ACC_OP);
                sp = a[31] ^ b[31] ^ neg;
                sd = d[31] ^ ((op == fp_slice_pkg::FUSED_NEG_MUL_ACC_OP) ||
                              (op == fp_slice_pkg::FUSED_NEG_MUL_SUB_OP));
                prod = {|a[30:23], a[22:0]} * {|b[30:23], b[22:0]};
                if (a[30:23] == 8'h00 || b[30:23] == 8'h00) prod = '0;
                ep = ea + eb;
                df = ep - ed;
                // Far-off addend shrinks to a sticky one; accepted inexactness
                if (df > `FMA_LEFT_MAX) begin
                    xp = {48'h0, prod} << `FMA_LEFT_MAX;
                    xd = {95'h0, d[30:23] != 8'h00};
                    ep = ep - `FMA_LEFT_MAX;
                end else if (df >= 0) begin
                    xp = {48'h0, prod} << df;
                    xd = md;
                    ep = ed;
                end else if (-df > `FMA_RIGHT_MAX) begin
                    xd = md << `FMA_RIGHT_MAX;
                    xp = {95'h0, |prod};
                    ep = ed - `FMA_RIGHT_MAX;
                end else begin
                    xd = md << (-df);
                    xp = {48'h0, prod};
                end
                if (sp == sd) compute = pack(sp, ep, xp + xd, rm, 1'b0);
                else if (xp >= xd) compute = pack(sp, ep, xp - xd, rm, 1'b0);
                else compute = pack(sd, ep, xd - xp, rm, 1'b0);
            end
        endcase
    endfunction

    // Next-state logic: one-cycle arithmetic or the multiple-load sequence
    always_comb begin
        next_state = state;
        next_busy = busy;
        next_resValid = 1'b0;
        next_resIdx = resIdx;
        next_resData = resData;
        next_baseValid = 1'b0;
        next_baseData = baseData;
        next_memRead = 1'b0;
        next_memAddr = memAddr;
        next_rdPend = memRead;
        next_addr = addr;
        next_left = left;
        next_idx = idx;
        next_wb = wb;
        case (state)
            fp_slice_pkg::ST_IDLE: begin
                if (link.reqValid && link.reqOp == fp_slice_pkg::MULTI_REG_LOAD_OP) begin
                    next_left = link.dblRegs ? {link.regCount, 1'b0} : {1'b0, link.regCount};
                    next_addr = link.decBefore ?
                        link.reqBase - {23'h0, next_left, 2'b00} : link.reqBase;
                    next_baseData = link.decBefore ? next_addr :
                        link.reqBase + {23'h0, next_left, 2'b00};
                    next_wb = link.writeBack;
                    next_idx = link.reqDest;
                    next_busy = 1'b1;
                    next_state = fp_slice_pkg::ST_LOAD;
                end else if (link.reqValid) begin
                    // Only the destination is written; flags are untouched
                    next_resValid = 1'b1;
                    next_resIdx = link.reqDest;
                    next_resData = compute(link.reqOp, link.reqA, link.reqB, link.reqD,
                        link.reqType, link.roundSel, link.toHalf, link.topHalf,
                        int'(link.fbits), link.rmode);
                end
            end
            fp_slice_pkg::ST_LOAD: begin
                if (left != 7'h00) begin
                    next_memRead = 1'b1;
                    next_memAddr = addr;
                    next_addr = addr + `WORD_BYTES;
                    next_left = left - 7'h01;
                end
                // Memory answers one cycle after the strobe
                if (rdPend) begin
                    next_resValid = 1'b1;
                    next_resData = memData;
                    next_resIdx = idx;
                    next_idx = idx + 5'h01;
                end
                if (left == 7'h00 && !memRead && !rdPend) begin
                    next_baseValid = wb;
                    next_busy = 1'b0;
                    next_state = fp_slice_pkg::ST_IDLE;
                end
            end
            default: next_state = fp_slice_pkg::ST_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= fp_slice_pkg::ST_IDLE;
            busy <= 1'b0;
            resValid <= 1'b0;
            resIdx <= 5'h00;
            resData <= 32'h0;
            baseValid <= 1'b0;
            baseData <= 32'h0;
            memRead <= 1'b0;
            memAddr <= 32'h0;
            rdPend <= 1'b0;
            left <= 7'h00;
        end else begin
            state <= next_state;
            busy <= next_busy;
            resValid <= next_resValid;
            resIdx <= next_resIdx;
            resData <= next_resData;
            baseValid <= next_baseValid;
            baseData <= next_baseData;
            memRead <= next_memRead;
            memAddr <= next_memAddr;
            rdPend <= next_rdPend;
            addr <= next_addr;
            left <= next_left;
            idx <= next_idx;
            wb <= next_wb;
        end
    end

    assign link.busy = busy;
    assign link.resValid = resValid;
    assign link.resIdx = resIdx;
    assign link.resData = resData;
    assign link.baseValid = baseValid;
    assign link.baseData = baseData;
endmodule

// >>> fp_issue_end.sv
// Core-side issuing end: checks operands, drives the link, returns results
`timescale 1ns/1ps
`include "fp_slice_params.svh"
module fp_issue_end (
    input  wire logic              clk,
    input  wire logic              rst_n,
    fp_link_if.host                link,
    input  wire logic              cmdValid,
    input  wire fp_slice_pkg::op_e cmdOp,
    input  wire logic [31:0]       cmdA,
    input  wire logic [31:0]       cmdB,
    input  wire logic [31:0]       cmdD,
    input  wire logic [4:0]        cmdDest,
    input  wire logic              cmdRoundSel,
    input  wire logic [1:0]        cmdType,
    input  wire logic              cmdToHalf,
    input  wire logic              cmdTopHalf,
    input  wire logic [5:0]        cmdFbits,
    input  wire logic [1:0]        fpscrRmode,
    input  wire logic [31:0]       cmdBase,
    input  wire logic [5:0]        cmdCount,
    input  wire logic              cmdDouble,
    input  wire logic              cmdSizeGiven,
    input  wire logic              cmdSize64,
    input  wire logic              cmdDecBefore,
    input  wire logic              cmdWriteBack,
    output logic                   ready,
    output logic                   cmdRefused,
    output logic                   wrValid,
    output logic [4:0]             wrIdx,
    output logic [31:0]            wrData,
    output logic                   baseWrValid,
    output logic [31:0]            baseWrData
);
    logic legal, take;
    logic next_ready, next_refused, next_reqValid;

    // Operand checks owed to the slice
    always_comb begin
        legal = 1'b1;
        if (cmdOp == fp_slice_pkg::CONVERT_F2X_OP || cmdOp == fp_slice_pkg::CONVERT_X2F_OP) begin
            if (!cmdType[`TYPE_W32_BIT] && cmdFbits > `FIX16_MAX_FBITS) legal = 1'b0;
            if (cmdType[`TYPE_W32_BIT] && (cmdFbits < `FIX32_MIN_FBITS ||
                cmdFbits > `FIX32_MAX_FBITS)) legal = 1'b0;
        end
        if (cmdOp == fp_slice_pkg::MULTI_REG_LOAD_OP) begin
            if (cmdDecBefore && !cmdWriteBack) legal = 1'b0;
            if (cmdSizeGiven && cmdSize64 != cmdDouble) legal = 1'b0;
            if (cmdCount == 6'h00) legal = 1'b0;
            if (cmdDouble && cmdCount > `MAX_DOUBLE_REGS) legal = 1'b0;
        end
        take = cmdValid && ready;
        next_reqValid = take && legal;
        next_refused = take && !legal;
        // Low until answer or load end
        next_ready = !take && !link.reqValid && !link.busy;
    end

    // Registered link drive and result return
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ready <= 1'b0;
            cmdRefused <= 1'b0;
            wrValid <= 1'b0;
            wrIdx <= 5'h00;
            wrData <= 32'h0;
            baseWrValid <= 1'b0;
            baseWrData <= 32'h0;
            // Payload only matters beside reqValid, so it keeps no reset
            link.reqValid <= 1'b0;
        end else begin
            ready <= next_ready;
            cmdRefused <= next_refused;
            wrValid <= link.resValid;
            wrIdx <= link.resIdx;
            wrData <= link.resData;
            baseWrValid <= link.baseValid;
            baseWrData <= link.baseData;
            link.reqValid <= next_reqValid;
            if (take) begin
                link.reqOp <= cmdOp;
                link.reqA <= cmdA;
                link.reqB <= cmdB;
                link.reqD <= cmdD;
                link.reqDest <= cmdDest;
                link.roundSel <= cmdRoundSel;
                link.reqType <= cmdType;
                link.toHalf <= cmdToHalf;
                link.topHalf <= cmdTopHalf;
                link.fbits <= cmdFbits;
                link.rmode <= fpscrRmode;
                link.reqBase <= cmdBase;
                link.regCount <= cmdCount;
                link.dblRegs <= cmdDouble;
                link.decBefore <= cmdDecBefore;
                link.writeBack <= cmdWriteBack;
            end
        end
    end
endmodule

// >>> fp_link_asserts.sv
// Link checker: timing and data relations between issuing end and slice
`timescale 1ns/1ps
module fp_link_asserts (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              reqValid,
    input wire fp_slice_pkg::op_e reqOp,
    input wire logic [31:0]       reqD,
    input wire logic [4:0]        reqDest,
    input wire logic [1:0]        reqType,
    input wire logic              toHalf,
    input wire logic [31:0]       reqBase,
    input wire logic [5:0]        regCount,
    input wire logic              dblRegs,
    input wire logic              decBefore,
    input wire logic              writeBack,
    input wire logic              busy,
    input wire logic              resValid,
    input wire logic [4:0]        resIdx,
    input wire logic [31:0]       resData,
    input wire logic              baseValid,
    input wire logic [31:0]       baseData
);
    logic [31:0] nBytes;
    logic [31:0] wantBase;
    logic        wantWb;
    logic        isLoad;
    logic        isF2x;
    // Bytes of a load list; doubles are two words each
    assign nBytes = {23'h00_0000, regCount, 3'h0} >> !dblRegs;
    assign isLoad = reqValid && reqOp == fp_slice_pkg::MULTI_REG_LOAD_OP;
    assign isF2x = reqValid && reqOp == fp_slice_pkg::CONVERT_F2X_OP;
    // Expected base, captured at the request
    always_ff @(posedge clk) begin
        if (isLoad) begin
            wantWb <= writeBack;
            wantBase <= decBefore ? reqBase - nBytes : reqBase + nBytes;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_ARITH_RES: assert property (reqValid && !isLoad |=> resValid && resIdx == $past(reqDest))
        else $error("result late or misplaced");
    AST_RES_PULSE: assert property (resValid && !busy && !reqValid |=> !resValid)
        else $error("result not a single pulse");
    AST_LOAD_BUSY: assert property (isLoad |=> busy [*3])
        else $error("load not busy");
    AST_LOAD_IDX: assert property (isLoad |-> ##4 resValid && resIdx == $past(reqDest, 4))
        else $error("first load word misplaced");
    AST_HALF_KEEP: assert property (reqValid && toHalf && reqOp == fp_slice_pkg::CONVERT_BOTTOM_HALF_OP
        |=> resData[31:16] == $past(reqD[31:16])) else $error("kept half changed");
    AST_SIGN_EXT: assert property (isF2x && reqType == 2'h0 |=> resData[31:16] == {16{resData[15]}})
        else $error("no sign extension");
    AST_ZERO_EXT: assert property (isF2x && reqType == 2'h1 |=> resData[31:16] == 16'h0000)
        else $error("no zero extension");
    AST_BASE_WB: assert property (baseValid |-> wantWb && baseData == wantBase)
        else $error("wrong base write-back");
    cover property (isLoad && decBefore);
    cover property (baseValid);
    cover property (reqValid && reqOp == fp_slice_pkg::FUSED_NEG_MUL_SUB_OP);
endmodule

// >>> tb.sv
// Testbench: issuing end and slice joined over the link
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmdValid, cmdRoundSel, cmdToHalf, cmdTopHalf, cmdDouble, cmdDecBefore, cmdWriteBack;
    logic cmdSize64;
    logic ready, cmdRefused, wrValid, baseWrValid, memRead, refd;
    logic [31:0] cmdA, cmdD, cmdBase, wrData, baseWrData, memAddr, memData;
    logic [5:0] cmdFbits, cmdCount;
    logic [4:0] cmdDest, wrIdx;
    logic [1:0] cmdType, fpscrRmode;
    fp_slice_pkg::op_e cmdOp = fp_slice_pkg::CONVERT_F2I_OP;
    logic [36:0] wq[$];
    logic [31:0] bq[$];
    int errorCnt = 0;
    int compares = 0;
    int cyc = 0;
    fp_link_if lnk ();
    fp_issue_end fp_issue_end_i (.clk, .rst_n, .link(lnk), .cmdValid, .cmdOp, .cmdA, .cmdB(cmdD),
        .cmdD, .cmdDest, .cmdRoundSel, .cmdType, .cmdToHalf, .cmdTopHalf, .cmdFbits, .fpscrRmode,
        .cmdBase, .cmdCount, .cmdDouble, .cmdSizeGiven(1'b1), .cmdSize64, .cmdDecBefore,
        .cmdWriteBack, .ready, .cmdRefused, .wrValid, .wrIdx, .wrData, .baseWrValid, .baseWrData);
    fp_convert_fma_load_unit fp_convert_fma_load_unit_i (.clk, .rst_n, .link(lnk), .memRead,
        .memAddr, .memData);
    fp_link_asserts fp_link_asserts_i (.clk, .rst_n, .reqValid(lnk.reqValid), .reqOp(lnk.reqOp),
        .reqD(lnk.reqD), .reqDest(lnk.reqDest), .reqType(lnk.reqType), .toHalf(lnk.toHalf),
        .reqBase(lnk.reqBase), .regCount(lnk.regCount), .dblRegs(lnk.dblRegs),
        .decBefore(lnk.decBefore), .writeBack(lnk.writeBack), .busy(lnk.busy),
        .resValid(lnk.resValid), .resIdx(lnk.resIdx), .resData(lnk.resData),
        .baseValid(lnk.baseValid), .baseData(lnk.baseData));
    always #4 clk = ~clk;
    // Memory answers a cycle after a read; idle data wanders
    always @(posedge clk) memData <= memRead ? ~memAddr : ~memData;
    // Collect what the issuing end hands back, sampled mid-cycle
    always @(negedge clk) begin
        if (wrValid === 1'b1) wq.push_back({wrIdx, wrData});
        if (baseWrValid === 1'b1) bq.push_back(baseWrData);
        if (cmdRefused === 1'b1) refd = 1'b1;
    end
    // Hang guard; the tests need under a hundred cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errorCnt++;
            testDone();
        end
    end
    task automatic cmp(input string n, input logic [36:0] e, input logic [36:0] s);
        compares++;
        if (s !== e) begin
            errorCnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // One command; refusal shows as bit 32 of the seen value
    task automatic run(input fp_slice_pkg::op_e op, input logic [31:0] a, d, input logic [32:0] e);
        cmdOp <= op;
        cmdA <= a;
        cmdD <= d;
        cmdValid <= 1'b1;
        refd = 1'b0;
        wq.delete();
        bq.delete();
        do @(negedge clk); while (ready !== 1'b1);
        @(posedge clk);
        cmdValid <= 1'b0;
        do @(negedge clk); while (ready !== 1'b0);
        do @(negedge clk); while (ready !== 1'b1);
        @(posedge clk);
        cmp(op.name(), {4'h0, e}, {4'h0, refd ? 33'h1_0000_0000 : {1'b0, wq[$][31:0]}});
        $display("test %s done", op.name());
    endtask
    task automatic testDone();
        $display("comparisons %0d mismatches %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        {cmdValid, cmdRoundSel, cmdToHalf, cmdTopHalf, cmdDouble, cmdDecBefore, cmdWriteBack} = '0;
        {cmdA, cmdD, cmdBase, memData, cmdFbits, cmdCount, cmdDest, cmdType, fpscrRmode} = '0;
        cmdSize64 = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        run(fp_slice_pkg::FUSED_MUL_ACC_OP, 32'h4000_0000, 32'h4040_0000, 33'h0_4110_0000);
        run(fp_slice_pkg::FUSED_MUL_SUB_OP, 32'h4000_0000, 32'h4040_0000, 33'h0_C040_0000);
        run(fp_slice_pkg::FUSED_NEG_MUL_ACC_OP, 32'h4000_0000, 32'h4040_0000, 33'h0_C110_0000);
        run(fp_slice_pkg::FUSED_NEG_MUL_SUB_OP, 32'h4000_0000, 32'h4040_0000, 33'h0_4040_0000);
        run(fp_slice_pkg::FP_DIVIDE_OP, 32'h4040_0000, 32'h4000_0000, 33'h0_3FC0_0000);
        cmdType <= 2'h2;
        run(fp_slice_pkg::CONVERT_F2I_OP, 32'h4030_0000, 32'h0, 33'h2);
        cmdRoundSel <= 1'b1;
        run(fp_slice_pkg::CONVERT_F2I_OP, 32'h4030_0000, 32'h0, 33'h3);
        cmdType <= 2'h3;
        run(fp_slice_pkg::CONVERT_I2F_OP, 32'hFFFF_FFFF, 32'h0, 33'h0_4F80_0000);
        cmdType <= 2'h0;
        cmdFbits <= 6'h04;
        run(fp_slice_pkg::CONVERT_F2X_OP, 32'h0, 32'hBFC0_0000, 33'h0_FFFF_FFE8);
        cmdType <= 2'h1;
        run(fp_slice_pkg::CONVERT_X2F_OP, 32'h0, 32'hFFFF_0018, 33'h0_3FC0_0000);
        cmdFbits <= 6'h11;
        run(fp_slice_pkg::CONVERT_F2X_OP, 32'h0, 32'h3F80_0000, 33'h1_0000_0000);
        cmdToHalf <= 1'b1;
        run(fp_slice_pkg::CONVERT_BOTTOM_HALF_OP, 32'h3F80_0000, 32'h1234_5678, 33'h0_1234_3C00);
        cmdTopHalf <= 1'b1;
        run(fp_slice_pkg::CONVERT_TOP_HALF_OP, 32'h3F80_0000, 32'h1234_5678, 33'h0_3C00_5678);
        cmdBase <= 32'h0000_0100;
        cmdCount <= 6'h03;
        cmdDest <= 5'h04;
        cmdWriteBack <= 1'b1;
        run(fp_slice_pkg::MULTI_REG_LOAD_OP, 32'h0, 32'h0, 33'h0_FFFF_FEF7);
        cmp("first word", {5'h04, 32'hFFFF_FEFF}, wq[0]);
        cmp("base", {5'h00, 32'h0000_010C}, {5'h00, bq[0]});
        cmdDecBefore <= 1'b1;
        cmdWriteBack <= 1'b0;
        run(fp_slice_pkg::MULTI_REG_LOAD_OP, 32'h0, 32'h0, 33'h1_0000_0000);
        cmdWriteBack <= 1'b1;
        cmdDouble <= 1'b1;
        cmdCount <= 6'h01;
        cmdBase <= 32'h0000_0200;
        run(fp_slice_pkg::MULTI_REG_LOAD_OP, 32'h0, 32'h0, 33'h1_0000_0000);
        cmdSize64 <= 1'b1;
        run(fp_slice_pkg::MULTI_REG_LOAD_OP, 32'h0, 32'h0, 33'h0_FFFF_FE03);
        cmp("base", {5'h00, 32'h0000_01F8}, {5'h00, bq[0]});
        testDone();
    end
endmodule
